// File: common/l2_intc_pkg.sv
// Constants and carrier types for the second-level interrupt handler
package l2_intc_pkg;

  localparam int unsigned NUM_LINES = 16;

  // Handler register space (byte offsets)
  localparam logic [6:0] PEND_OFS      = 7'h00;
  localparam logic [6:0] MASK_OFS      = 7'h02;
  localparam logic [6:0] NSRC_OFS      = 7'h04;
  localparam logic [6:0] FSRC_OFS      = 7'h06;
  localparam logic [6:0] CTRL_OFS      = 7'h08;
  localparam logic [6:0] SWSET_OFS     = 7'h0A;
  localparam logic [6:0] LVL_BASE_OFS  = 7'h0C;
  localparam logic [6:0] LVL_STEP      = 7'h02;
  localparam logic [6:0] LVL_LAST_OFS  = 7'h2A;

  // Interface register space (byte offsets)
  localparam logic [6:0] SENSE_HI_OFS  = 7'h00;
  localparam logic [6:0] SENSE_LO_OFS  = 7'h02;

  // Field positions
  localparam int unsigned PRIO_MSB       = 5;
  localparam int unsigned PRIO_LSB       = 2;
  localparam int unsigned SENS_BIT       = 1;
  localparam int unsigned ROUTE_BIT      = 0;
  localparam int unsigned NORMAL_REL_BIT = 0;
  localparam int unsigned FAST_REL_BIT   = 1;
  localparam int unsigned HOST_SENSE_BIT = 7;
  localparam int unsigned NMI_SENSE_BIT  = 6;

  // Reset values
  localparam logic [15:0] PEND_RST     = 16'h0000;
  localparam logic [15:0] MASK_RST     = 16'hFFFF;
  localparam logic [3:0]  SRC_RST      = 4'h0;
  localparam logic [5:0]  LVL_RST      = 6'h00;
  localparam logic [7:0]  SENSE_HI_RST = 8'h00;
  localparam logic [15:0] SENSE_LO_RST = 16'h0000;
  localparam logic [15:0] READ_ZERO    = 16'h0000;

  // Cycles that a cleared request needs to leave the arbitration pipe
  localparam logic [1:0]  SETTLE_CYCLES = 2'h2;

  // One register access on the private peripheral bus
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic        iface_space;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } bus_rsp_t;

  // Winner of one arbitration
  typedef struct packed {
    logic       valid;
    logic [3:0] line;
  } winner_t;

endpackage

// File: verilog/l2_intc.sv
// Second-level interrupt handler with interface sensitivity registers
//
// Overview of operation
// - Edge inputs latch into pending register bits
// - Level inputs bypass latch, feed arbitration directly
// - Pending write: zero clears, one keeps
// - Mask bit one masks line; reset masks all
// - Best unmasked request held in hidden register
// - Priority in bits 5:2, zero most urgent
// - Equal priority prefers higher line number
// - Bit 1: zero rising edge, one level
// - Bit 0 routes to normal or fast
// - Idle output with winner asserts, records number
// - Source read clears edge pending; output stays
// - Control bit 0 releases normal output
// - Control bit 1 releases fast output
// - Release re-runs arbitration for next request
// - Software set rising bit fires edge lines only
// - Software set ORed before mask; reads zero
// - High interface register: host, nmi, channels
// - Low interface register: 16 bits, resets zero
// - All registers 16 bits on private bus
// - Level register x at twelve plus 2x
// - Single request reaches output in five cycles
`timescale 1ns/1ps
module l2_intc
  import l2_intc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [15:0] line_req,
  input  wire bus_req_t    bus_req,
  output bus_rsp_t         bus_rsp,
  output logic             normal_req,
  output logic             fast_req,
  output logic [7:0]       sense_select_high,
  output logic [15:0]      sense_select_low
);

  logic [15:0] in_reg,      in_next;
  logic [15:0] sw_reg,      sw_next;
  logic [15:0] prev_reg,    prev_next;
  logic [15:0] pend_reg,    pend_next;
  logic [15:0] mask_reg,    mask_next;
  logic [15:0] act_reg,     act_next;
  logic [15:0] live_reg,    live_next;
  logic [5:0]  lvl_reg [NUM_LINES];
  logic [5:0]  lvl_next [NUM_LINES];
  winner_t     nwin_reg,    nwin_next;
  winner_t     fwin_reg,    fwin_next;
  logic        nout_reg,    nout_next;
  logic        fout_reg,    fout_next;
  logic [3:0]  nsrc_reg,    nsrc_next;
  logic [3:0]  fsrc_reg,    fsrc_next;
  logic [1:0]  nhold_reg,   nhold_next;
  logic [1:0]  fhold_reg,   fhold_next;
  logic [7:0]  shi_reg,     shi_next;
  logic [15:0] slo_reg,     slo_next;
  bus_rsp_t    rsp_reg,     rsp_next;

  logic [15:0] edge_mode;
  logic [15:0] fast_route;
  logic [15:0] edge_in;
  logic [15:0] edge_set;
  logic        hwr;
  logic        hrd;
  logic        nrel;
  logic        frel;
  logic        iwr;
  logic        ird;
  logic [6:0]  lvl_ofs [NUM_LINES];

  // Lowest priority value wins; the later, higher line wins a tie
  function automatic winner_t arbitrate(input logic [15:0] act, input logic [15:0] route,
                                        input logic want_fast,
                                        input logic [5:0] lvl [NUM_LINES]);
    winner_t w;
    logic [3:0] best;
    w = '{valid: 1'b0, line: 4'h0};
    best = 4'hF;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (act[i] && (route[i] == want_fast) &&
          (!w.valid || lvl[i][PRIO_MSB:PRIO_LSB] <= best)) begin
        w.valid = 1'b1;
        w.line  = 4'(i);
        best    = lvl[i][PRIO_MSB:PRIO_LSB];
      end
    end
    return w;
  endfunction

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      edge_mode[i]  = ~lvl_reg[i][SENS_BIT];
      fast_route[i] = lvl_reg[i][ROUTE_BIT];
      lvl_ofs[i]    = LVL_BASE_OFS + 7'(i) * LVL_STEP;
    end
  end

  assign hwr  = bus_req.strobe && bus_req.write && !bus_req.iface_space;
  assign hrd  = bus_req.strobe && !bus_req.write && !bus_req.iface_space;
  assign iwr  = bus_req.strobe && bus_req.write && bus_req.iface_space;
  assign ird  = bus_req.strobe && !bus_req.write && bus_req.iface_space;
  assign nrel = hwr && (bus_req.addr == CTRL_OFS) && bus_req.wdata[NORMAL_REL_BIT];
  assign frel = hwr && (bus_req.addr == CTRL_OFS) && bus_req.wdata[FAST_REL_BIT];

  // Request capture; the live stage keeps level latency equal to the edge path
  always_comb begin
    in_next   = line_req;
    live_next = in_reg;
    edge_in   = in_reg | sw_reg;
    prev_next = edge_in;
    sw_next   = sw_reg;
    if (hwr && bus_req.addr == SWSET_OFS) begin
      sw_next = bus_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_reg   <= 16'h0000;
      live_reg <= 16'h0000;
      sw_reg   <= 16'h0000;
      prev_reg <= 16'h0000;
    end else begin
      in_reg   <= in_next;
      live_reg <= live_next;
      sw_reg   <= sw_next;
      prev_reg <= prev_next;
    end
  end

  // Pending register and active set
  always_comb begin
    edge_set  = edge_in & ~prev_reg & edge_mode;
    pend_next = pend_reg;
    if (hwr && bus_req.addr == PEND_OFS) begin
      pend_next = pend_next & bus_req.wdata;
    end
    // Only a raised output names a line; idle reads leave line 0 alone
    if (hrd && bus_req.addr == NSRC_OFS && nout_reg && edge_mode[nsrc_reg]) begin
      pend_next[nsrc_reg] = 1'b0;
    end
    if (hrd && bus_req.addr == FSRC_OFS && fout_reg && edge_mode[fsrc_reg]) begin
      pend_next[fsrc_reg] = 1'b0;
    end
    // A new edge in the same cycle as a clear wins
    pend_next = (pend_next | edge_set) & edge_mode;
    // Level lines see the live input only, never the software set
    act_next  = ((pend_reg & edge_mode) | (live_reg & ~edge_mode)) & ~mask_reg;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= PEND_RST;
      act_reg  <= 16'h0000;
    end else begin
      pend_reg <= pend_next;
      act_reg  <= act_next;
    end
  end

  // Arbitration and output handshake
  always_comb begin
    nwin_next  = arbitrate(act_reg, fast_route, 1'b0, lvl_reg);
    fwin_next  = arbitrate(act_reg, fast_route, 1'b1, lvl_reg);
    nout_next  = nout_reg;
    fout_next  = fout_reg;
    nsrc_next  = nsrc_reg;
    fsrc_next  = fsrc_reg;
    nhold_next = (nhold_reg != 2'h0) ? nhold_reg - 2'h1 : 2'h0;
    fhold_next = (fhold_reg != 2'h0) ? fhold_reg - 2'h1 : 2'h0;
    // Hold-off lets a cleared request drain past the winner stage
    if (nrel) begin
      nout_next  = 1'b0;
      nsrc_next  = SRC_RST;
      nhold_next = SETTLE_CYCLES;
    end else if (!nout_reg && nhold_reg == 2'h0 && nwin_reg.valid) begin
      nout_next = 1'b1;
      nsrc_next = nwin_reg.line;
    end
    if (frel) begin
      fout_next  = 1'b0;
      fsrc_next  = SRC_RST;
      fhold_next = SETTLE_CYCLES;
    end else if (!fout_reg && fhold_reg == 2'h0 && fwin_reg.valid) begin
      fout_next = 1'b1;
      fsrc_next = fwin_reg.line;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      nwin_reg  <= '0;
      fwin_reg  <= '0;
      nout_reg  <= 1'b0;
      fout_reg  <= 1'b0;
      nsrc_reg  <= SRC_RST;
      fsrc_reg  <= SRC_RST;
      nhold_reg <= 2'h0;
      fhold_reg <= 2'h0;
    end else begin
      nwin_reg  <= nwin_next;
      fwin_reg  <= fwin_next;
      nout_reg  <= nout_next;
      fout_reg  <= fout_next;
      nsrc_reg  <= nsrc_next;
      fsrc_reg  <= fsrc_next;
      nhold_reg <= nhold_next;
      fhold_reg <= fhold_next;
    end
  end

  // Configuration registers
  always_comb begin
    mask_next = mask_reg;
    shi_next  = shi_reg;
    slo_next  = slo_reg;
    for (int i = 0; i < NUM_LINES; i++) begin
      lvl_next[i] = lvl_reg[i];
    end
    // Interface sense bits only drive the outputs; the handler ignores them
    if (iwr && bus_req.addr == SENSE_HI_OFS) begin
      shi_next = bus_req.wdata[7:0];
    end
    if (iwr && bus_req.addr == SENSE_LO_OFS) begin
      slo_next = bus_req.wdata;
    end
    if (hwr && bus_req.addr == MASK_OFS) begin
      mask_next = bus_req.wdata;
    end
    for (int i = 0; i < NUM_LINES; i++) begin
      if (hwr && bus_req.addr == lvl_ofs[i]) begin
        lvl_next[i] = bus_req.wdata[5:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= MASK_RST;
      shi_reg  <= SENSE_HI_RST;
      slo_reg  <= SENSE_LO_RST;
      for (int i = 0; i < NUM_LINES; i++) begin
        lvl_reg[i] <= LVL_RST;
      end
    end else begin
      mask_reg <= mask_next;
      shi_reg  <= shi_next;
      slo_reg  <= slo_next;
      for (int i = 0; i < NUM_LINES; i++) begin
        lvl_reg[i] <= lvl_next[i];
      end
    end
  end

  // Read path: a write answers with zero data
  always_comb begin
    rsp_next.ack   = bus_req.strobe;
    rsp_next.rdata = READ_ZERO;
    if (ird && bus_req.addr == SENSE_HI_OFS) begin
      rsp_next.rdata = {8'h00, shi_reg};
    end
    if (ird && bus_req.addr == SENSE_LO_OFS) begin
      rsp_next.rdata = slo_reg;
    end
    for (int i = 0; i < NUM_LINES; i++) begin
      if (hrd && bus_req.addr == lvl_ofs[i]) begin
        rsp_next.rdata = {10'h000, lvl_reg[i]};
      end
    end
    if (hrd) begin
      case (bus_req.addr)
        PEND_OFS:  rsp_next.rdata = pend_reg;
        MASK_OFS:  rsp_next.rdata = mask_reg;
        NSRC_OFS:  rsp_next.rdata = {12'h000, nsrc_reg};
        FSRC_OFS:  rsp_next.rdata = {12'h000, fsrc_reg};
        CTRL_OFS:  rsp_next.rdata = READ_ZERO;
        SWSET_OFS: rsp_next.rdata = READ_ZERO;
        default:   ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign bus_rsp           = rsp_reg;
  assign normal_req        = nout_reg;
  assign fast_req          = fout_reg;
  assign sense_select_high = shi_reg;
  assign sense_select_low  = slo_reg;

endmodule

// File: sim/l2_intc_properties.sv
// Port-level assertions for the second-level interrupt handler
`timescale 1ns/1ps
module l2_intc_properties
  import l2_intc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [15:0] line_req,
  input wire bus_req_t    bus_req,
  input wire bus_rsp_t    bus_rsp,
  input wire logic        normal_req,
  input wire logic        fast_req,
  input wire logic [7:0]  sense_select_high,
  input wire logic [15:0] sense_select_low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire hw   = bus_req.strobe && bus_req.write && !bus_req.iface_space;
  wire hr   = bus_req.strobe && !bus_req.write && !bus_req.iface_space;
  wire iw   = bus_req.strobe && bus_req.write && bus_req.iface_space;
  wire nrel = hw && bus_req.addr == CTRL_OFS && bus_req.wdata[NORMAL_REL_BIT];
  wire frel = hw && bus_req.addr == CTRL_OFS && bus_req.wdata[FAST_REL_BIT];
  ack_follows_a: assert property (bus_req.strobe |=> bus_rsp.ack)
    else $error("ack missing after access");
  ack_stray_a: assert property (!bus_req.strobe |=> !bus_rsp.ack)
    else $error("ack without access");
  swset_zero_a: assert property (hr && bus_req.addr == SWSET_OFS |=> bus_rsp.rdata == READ_ZERO)
    else $error("software set read not zero");
  write_zero_a: assert property (bus_req.strobe && bus_req.write |=> bus_rsp.rdata == READ_ZERO)
    else $error("write answered with nonzero data");
  normal_drop_a: assert property (nrel |=> !normal_req [*2])
    else $error("normal output not released");
  fast_drop_a: assert property (frel |=> !fast_req [*2])
    else $error("fast output not released");
  normal_hold_a: assert property ($fell(normal_req) |-> $past(nrel))
    else $error("normal output dropped without release");
  fast_hold_a: assert property ($fell(fast_req) |-> $past(frel))
    else $error("fast output dropped without release");
  src_read_a: assert property (hr && bus_req.addr == NSRC_OFS && normal_req |=> normal_req)
    else $error("source read dropped output");
  sense_low_a: assert property (iw && bus_req.addr == SENSE_LO_OFS
    |=> sense_select_low == $past(bus_req.wdata))
    else $error("low sense register not written");
  sense_high_a: assert property (iw && bus_req.addr == SENSE_HI_OFS
    |=> sense_select_high == $past(bus_req.wdata[7:0]))
    else $error("high sense register not written");
  cover property ($rose(normal_req));
  cover property ($rose(fast_req));
  cover property (nrel ##1 !normal_req);
endmodule

// File: sim/l2_core_model.sv
// Core model that counts interrupt entries on both request outputs
`timescale 1ns/1ps
module l2_core_model (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       normal_req,
  input  wire logic       fast_req,
  output logic [7:0]      taken
);
  logic n_reg;
  logic f_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n_reg <= 1'b0;
      f_reg <= 1'b0;
      taken <= 8'h00;
    end else begin
      n_reg <= normal_req;
      f_reg <= fast_req;
      taken <= taken + 8'(normal_req & !n_reg) + 8'(fast_req & !f_reg);
    end
  end
endmodule

// File: sim/l2_intc_test.sv
// Self-checking bench for the second-level interrupt handler
`timescale 1ns/1ps
module l2_intc_test;
  import l2_intc_pkg::*;
  logic        mclk, resetn, normal_req, fast_req;
  logic [15:0] line_req, sense_select_low, rv;
  logic [7:0]  sense_select_high, taken;
  logic [31:0] seed = 32'hA73F, r;
  bus_req_t    bus_req;
  bus_rsp_t    bus_rsp;
  int          fails, n_tests, n, k, c;
  l2_intc uut (.mclk(mclk), .resetn(resetn), .line_req(line_req), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .normal_req(normal_req), .fast_req(fast_req),
    .sense_select_high(sense_select_high), .sense_select_low(sense_select_low));
  l2_core_model core (.mclk(mclk), .resetn(resetn), .normal_req(normal_req),
    .fast_req(fast_req), .taken(taken));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] lvl(input logic [3:0] p, input logic s, input logic f);
    return {10'h000, p, s, f};
  endfunction
  function automatic logic [6:0] lofs(input logic [3:0] l);
    return LVL_BASE_OFS + LVL_STEP * 7'(l);
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic s, input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{1'b1, w, s, a, d};
    @(posedge mclk);
    bus_req.strobe <= 1'b0;
    #1;
    cmp(16'(bus_rsp.ack), 16'h0001);
    rv = bus_rsp.rdata;
  endtask
  task automatic wait_out(input logic f);
    for (n = 1; n <= 20; n++) begin
      @(posedge mclk);
      #1;
      if ((f ? fast_req : normal_req) === 1'b1) break;
    end
    if (n > 20) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic serve(input logic f, input logic [15:0] l);
    acc(1'b0, 1'b0, f ? FSRC_OFS : NSRC_OFS, 16'h0000);
    cmp(rv, l);
    cmp(16'(f ? fast_req : normal_req), 16'h0001);
    acc(1'b1, 1'b0, CTRL_OFS, f ? 16'h0002 : 16'h0001);
    cmp(16'({fast_req, normal_req}), 16'h0000);
  endtask
  initial begin
    resetn = 1'b0;
    line_req = '0;
    bus_req = '0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    acc(1'b0, 1'b0, MASK_OFS, 16'h0000);
    cmp(rv, MASK_RST);
    cmp(sense_select_low, SENSE_LO_RST);
    cmp({8'h00, sense_select_high}, {8'h00, SENSE_HI_RST});
    r = xs();
    acc(1'b1, 1'b1, SENSE_LO_OFS, r[15:0]);
    cmp(sense_select_low, r[15:0]);
    acc(1'b1, 1'b1, SENSE_HI_OFS, r[31:16]);
    cmp({8'h00, sense_select_high}, {8'h00, r[23:16]});
    acc(1'b0, 1'b1, SENSE_HI_OFS, 16'h0000);
    cmp(rv, {8'h00, r[23:16]});
    acc(1'b0, 1'b0, 7'h7E, 16'h0000);
    cmp(rv, 16'h0000);
    acc(1'b1, 1'b0, MASK_OFS, 16'h0000);
    $display("register test done");
    for (k = 0; k < 8; k++) begin
      r = xs();
      acc(1'b1, 1'b0, lofs(r[3:0]), lvl(r[7:4], 1'b0, r[8]));
      @(posedge mclk);
      line_req[r[3:0]] <= 1'b1;
      wait_out(r[8]);
      cmp(16'(n), 16'h0005);
      serve(r[8], 16'(r[3:0]));
      acc(1'b0, 1'b0, PEND_OFS, 16'h0000);
      cmp(rv, 16'h0000);
      acc(1'b0, 1'b0, r[8] ? FSRC_OFS : NSRC_OFS, 16'h0000);
      cmp(rv, 16'(SRC_RST));
      @(posedge mclk);
      line_req <= '0;
    end
    $display("random edge test done");
    acc(1'b1, 1'b0, MASK_OFS, 16'hFFFF);
    acc(1'b1, 1'b0, lofs(4'h6), lvl(4'h0, 1'b0, 1'b0));
    acc(1'b1, 1'b0, lofs(4'h7), lvl(4'h0, 1'b0, 1'b0));
    @(posedge mclk);
    line_req <= 16'h00C0;
    repeat (8) @(posedge mclk);
    #1;
    cmp(16'({fast_req, normal_req}), 16'h0000);
    acc(1'b0, 1'b0, PEND_OFS, 16'h0000);
    cmp(rv, 16'h00C0);
    acc(1'b1, 1'b0, PEND_OFS, 16'hFFBF);
    acc(1'b0, 1'b0, PEND_OFS, 16'h0000);
    cmp(rv, 16'h0080);
    acc(1'b1, 1'b0, MASK_OFS, 16'h0000);
    wait_out(1'b0);
    serve(1'b0, 16'h0007);
    @(posedge mclk);
    line_req <= '0;
    $display("mask test done");
    for (c = 0; c < 2; c++) begin
      acc(1'b1, 1'b0, lofs(4'h2), lvl(c ? 4'h3 : 4'h1, 1'b0, 1'b0));
      acc(1'b1, 1'b0, lofs(4'h9), lvl(c ? 4'h3 : 4'h4, 1'b0, 1'b0));
      @(posedge mclk);
      line_req <= 16'h0204;
      wait_out(1'b0);
      serve(1'b0, c ? 16'h0009 : 16'h0002);
      wait_out(1'b0);
      serve(1'b0, c ? 16'h0002 : 16'h0009);
      @(posedge mclk);
      line_req <= '0;
    end
    $display("priority test done");
    acc(1'b1, 1'b0, lofs(4'hB), lvl(4'h0, 1'b0, 1'b0));
    acc(1'b1, 1'b0, SWSET_OFS, 16'h0000);
    acc(1'b1, 1'b0, SWSET_OFS, 16'h0800);
    wait_out(1'b0);
    serve(1'b0, 16'h000B);
    acc(1'b0, 1'b0, SWSET_OFS, 16'h0000);
    cmp(rv, 16'h0000);
    acc(1'b1, 1'b0, lofs(4'hB), lvl(4'h0, 1'b1, 1'b0));
    acc(1'b1, 1'b0, SWSET_OFS, 16'h0000);
    acc(1'b1, 1'b0, SWSET_OFS, 16'h0800);
    repeat (8) @(posedge mclk);
    #1;
    cmp(16'(normal_req), 16'h0000);
    @(posedge mclk);
    line_req <= 16'h0800;
    wait_out(1'b0);
    cmp(16'(n), 16'h0005);
    acc(1'b0, 1'b0, PEND_OFS, 16'h0000);
    cmp(rv, 16'h0000);
    acc(1'b0, 1'b0, NSRC_OFS, 16'h0000);
    cmp(rv, 16'h000B);
    cmp(16'(normal_req), 16'h0001);
    @(posedge mclk);
    line_req <= '0;
    acc(1'b1, 1'b0, CTRL_OFS, 16'h0001);
    cmp(16'(normal_req), 16'h0000);
    repeat (8) @(posedge mclk);
    #1;
    cmp(16'(normal_req), 16'h0000);
    cmp(16'(taken), 16'h000F);
    $display("software set and level test done");
    end_sim();
  end
endmodule
bind l2_intc l2_intc_properties chk (.mclk(mclk), .resetn(resetn), .line_req(line_req),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .normal_req(normal_req), .fast_req(fast_req),
  .sense_select_high(sense_select_high), .sense_select_low(sense_select_low));
